// ==== sspi_pkg.sv ====
// sspi_pkg: object indices, field layouts, encodings and reset values
// assumes a 16-bit object index and 8-bit subindex on the mailbox port
package sspi_pkg;
  // object indices
  localparam logic [15:0] IDX_OUTPUT_MAP = 16'h1600;
  localparam logic [15:0] IDX_INPUT_MAP = 16'h1a00;
  localparam logic [15:0] IDX_HEALTH_MAP = 16'h1a01;
  localparam logic [15:0] IDX_FALLBACK_MODE = 16'h2100;
  localparam logic [15:0] IDX_FALLBACK_PATTERN = 16'h2102;
  localparam logic [15:0] IDX_FACTORY_RESTORE = 16'h2f00;
  localparam logic [15:0] IDX_INPUT_IMAGE = 16'h4000;
  localparam logic [15:0] IDX_HEALTH_WORD = 16'h4001;
  localparam logic [15:0] IDX_OUTPUT_IMAGE = 16'h5000;
  // subindices
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_ENTRY = 8'h01;
  localparam logic [7:0] MAP_COUNT_IO = 8'h02;
  localparam logic [7:0] MAP_COUNT_HEALTH = 8'h01;
  localparam logic [7:0] PATTERN_COUNT = 8'h01;
  // mapping entry lengths in bits
  localparam logic [7:0] LEN_BYTE = 8'h08;
  localparam logic [7:0] LEN_WORD = 8'h20;
  // mapping entry field positions
  localparam int MAP_IDX_LSB = 16;
  localparam int MAP_SUB_LSB = 8;
  localparam int MAP_LEN_LSB = 0;
  // fallback mode encodings
  localparam logic [7:0] FB_LOW = 8'h00;
  localparam logic [7:0] FB_HIGH = 8'h01;
  localparam logic [7:0] FB_HOLD = 8'h02;
  localparam logic [7:0] FB_PATTERN = 8'h03;
  // factory restore encodings
  localparam logic [7:0] FR_NORMAL = 8'h00;
  localparam logic [7:0] FR_RESTORE = 8'h01;
  // node state codes
  localparam logic [3:0] ST_INIT = 4'h1;
  localparam logic [3:0] ST_PREOP = 4'h2;
  localparam logic [3:0] ST_OP = 4'h8;
  // reset values
  localparam logic [7:0] RST_FALLBACK_MODE = 8'h00;
  localparam logic [7:0] RST_FALLBACK_PATTERN = 8'h00;
  localparam logic [7:0] RST_FACTORY_RESTORE = 8'h00;
  localparam logic [3:0] RST_OUTPUTS = 4'h0;
  // health word bits
  localparam int HB_OUT_SHORT = 0;
  localparam int HB_OUT_OVERV = 1;
  localparam int HB_ACT_SHORT = 2;
  localparam int HB_ACT_UNDERV = 3;
  localparam int HB_SEN_OVERV = 4;
  localparam int HB_SEN_UNDERV = 5;
  localparam int NUM_FAULTS = 6;
  // arbiter grant
  typedef enum logic [1:0] {
    SSPI_GR_IDLE = 2'b00,
    SSPI_GR_MBX = 2'b01,
    SSPI_GR_CYC = 2'b10
  } sspi_grant_e;
endpackage

// ==== sspi_top.sv ====
// sspi_top: fallback output logic and process image of an 8-in 4-out node
// assumes cyclic and mailbox requests from logic on the same clock;
// digital inputs and fault lines are pins and are synchronised here.
// restart_in is a one-cycle pulse from the node's own restart logic.
// Notes on behaviour
// - mailbox request served before any other request
// - one grant per cycle on shared data
// - not operational: outputs take fallback value
// - mode 00 low, 01 high, 02 hold, 03 pattern
// - pattern low four bits used only mode 03
// - fallback settings writable only in pre-operational
// - restore field: 00 normal, 01 restore, else reserved
// - requested restore acts at next restart
// - four-byte health word in input image
// - health bits 0..5 map to six faults
// - input byte: input 8 bit 7 down to 1
// - output byte: output 4 bit 3 down to 1
// - map entry: index, subindex, length fields
// - output map: output image, sub 01, 8 bits
// - input map: input image, sub 01, 8 bits
// - health map: health word, sub 01, 32 bits
// - node state readable, 08 means operational
`timescale 1ns/1ns
module sspi_top
  import sspi_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [3:0] node_state_in,
  input wire logic restart_in,
  input wire logic [7:0] dig_in,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  input wire logic mbx_req_in,
  input wire logic mbx_write_in,
  input wire logic [15:0] mbx_index_in,
  input wire logic [7:0] mbx_sub_in,
  input wire logic [31:0] mbx_wdata_in,
  input wire logic cyc_req_in,
  input wire logic [7:0] cyc_out_byte_in,
  output logic mbx_ack_out,
  output logic mbx_err_out,
  output logic [31:0] mbx_rdata_out,
  output logic cyc_ack_out,
  output logic [7:0] cyc_in_byte_out,
  output logic [31:0] cyc_health_out,
  output logic [3:0] node_state_out,
  output logic [3:0] dig_out,
  output logic factory_restore_out
);
  // settings and images
  logic [7:0] fallback_mode;
  logic [7:0] fallback_pattern;
  logic [7:0] factory_restore_request;
  logic [7:0] output_image;
  logic [7:0] input_image;
  logic [31:0] health_word;

  // pin synchroniser stages
  logic [7:0] in_s1;
  logic [7:0] in_s2;
  logic [7:0] in_s3;
  logic [NUM_FAULTS-1:0] flt_s1;
  logic [NUM_FAULTS-1:0] flt_s2;
  logic [NUM_FAULTS-1:0] flt_s3;

  // state decode, grant and next values
  logic is_op;
  logic is_preop;
  sspi_grant_e grant;
  logic [31:0] next_rdata;
  logic next_err;
  logic [3:0] next_dig;
  logic store_ok;
  logic restore_wr;

  // every code but operational counts as a fallback state
  assign is_op = (node_state_in == ST_OP);
  assign is_preop = (node_state_in == ST_PREOP);

  // pin synchronisers, three stages
  // stage one may go metastable, so only stage two reads it
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      in_s1 <= 8'h00;
      in_s2 <= 8'h00;
      in_s3 <= 8'h00;
      flt_s1 <= '0;
      flt_s2 <= '0;
      flt_s3 <= '0;
    end else begin
      in_s1 <= dig_in;
      in_s2 <= in_s1;
      in_s3 <= in_s2;
      flt_s1 <= fault_in;
      flt_s2 <= flt_s1;
      flt_s3 <= flt_s2;
    end
  end

  // image update once stages two and three agree, bit by bit
  // a one-cycle glitch never reaches the image
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_in
      always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
          input_image[gi] <= 1'b0;
        end else if (in_s2[gi] == in_s3[gi]) begin
          input_image[gi] <= in_s3[gi];
        end
      end
    end
    // health word: six fault bits, the rest reserved
    for (gi = 0; gi < 32; gi++) begin : g_hw
      if (gi < NUM_FAULTS) begin : g_f
        always_ff @(posedge clock_in) begin
          if (!rst_b_in) begin
            health_word[gi] <= 1'b0;
          end else if (flt_s2[gi] == flt_s3[gi]) begin
            health_word[gi] <= flt_s3[gi];
          end
        end
      end else begin : g_r
        assign health_word[gi] = 1'b0; // reserved bits
      end
    end
  endgenerate

  // arbiter: mailbox first, one party per cycle
  // mailbox wins a tie, so a setting write is never starved
  always_comb begin
    if (mbx_req_in) begin
      grant = SSPI_GR_MBX;
    end else if (cyc_req_in) begin
      grant = SSPI_GR_CYC;
    end else begin
      grant = SSPI_GR_IDLE;
    end
  end
  // grants are combinational, answers come a cycle later
  assign mbx_ack_out = (grant == SSPI_GR_MBX);
  assign cyc_ack_out = (grant == SSPI_GR_CYC);

  // map entry built from its three fields
  function automatic logic [31:0] map_entry(input logic [15:0] idx, input logic [7:0] len);
    map_entry = (32'(idx) << MAP_IDX_LSB) | (32'(SUB_ENTRY) << MAP_SUB_LSB) |
      (32'(len) << MAP_LEN_LSB);
  endfunction

  // mailbox read decode
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    // subindex 00 answers counts or the one-byte settings
    if (mbx_sub_in == SUB_COUNT) begin
      case (mbx_index_in)
        IDX_OUTPUT_MAP, IDX_INPUT_MAP, IDX_INPUT_IMAGE, IDX_OUTPUT_IMAGE: begin
          next_rdata = {24'h000000, MAP_COUNT_IO};
        end
        IDX_HEALTH_MAP, IDX_HEALTH_WORD: begin
          next_rdata = {24'h000000, MAP_COUNT_HEALTH};
        end
        IDX_FALLBACK_PATTERN: next_rdata = {24'h000000, PATTERN_COUNT};
        IDX_FALLBACK_MODE: next_rdata = {24'h000000, fallback_mode};
        IDX_FACTORY_RESTORE: next_rdata = {24'h000000, factory_restore_request};
        default: next_err = 1'b1;
      endcase
    end else if (mbx_sub_in == SUB_ENTRY) begin
      case (mbx_index_in)
        IDX_OUTPUT_MAP: begin
          next_rdata = map_entry(IDX_OUTPUT_IMAGE, LEN_BYTE);
        end
        IDX_INPUT_MAP: begin
          next_rdata = map_entry(IDX_INPUT_IMAGE, LEN_BYTE);
        end
        IDX_HEALTH_MAP: begin
          next_rdata = map_entry(IDX_HEALTH_WORD, LEN_WORD);
        end
        IDX_FALLBACK_PATTERN: next_rdata = {24'h000000, fallback_pattern};
        IDX_INPUT_IMAGE: next_rdata = {24'h000000, input_image};
        IDX_HEALTH_WORD: next_rdata = health_word;
        IDX_OUTPUT_IMAGE: next_rdata = {24'h000000, output_image};
        default: next_err = 1'b1;
      endcase
    end else begin
      next_err = 1'b1;
    end
    // writes: only the three settings objects accept them
    // a refused write leaves every setting as it was
    if (mbx_write_in) begin
      next_rdata = 32'h0000_0000;
      if (mbx_index_in == IDX_FALLBACK_MODE && mbx_sub_in == SUB_COUNT) begin
        next_err = !is_preop || (mbx_wdata_in[7:0] > FB_PATTERN);
      end else if (mbx_index_in == IDX_FALLBACK_PATTERN && mbx_sub_in == SUB_ENTRY) begin
        next_err = !is_preop;
      end else if (mbx_index_in == IDX_FACTORY_RESTORE && mbx_sub_in == SUB_COUNT) begin
        next_err = (mbx_wdata_in[7:0] > FR_RESTORE);
      end else begin
        next_err = 1'b1;
      end
    end
  end

  // mailbox answer registers
  // answer stands until the next granted mailbox access
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      mbx_rdata_out <= 32'h0000_0000;
      mbx_err_out <= 1'b0;
    end else if (grant == SSPI_GR_MBX) begin
      mbx_rdata_out <= next_rdata;
      mbx_err_out <= next_err;
    end
  end

  // a granted write that passed every check
  assign store_ok = (grant == SSPI_GR_MBX) && mbx_write_in && !next_err;
  assign restore_wr = store_ok && (mbx_index_in == IDX_FACTORY_RESTORE);

  // settings writes, gated by state, mode also by encoding
  // mode and pattern writes get here only in pre-operational, the decode refuses others
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      fallback_mode <= RST_FALLBACK_MODE;
      fallback_pattern <= RST_FALLBACK_PATTERN;
    end else if (store_ok) begin
      if (mbx_index_in == IDX_FALLBACK_MODE) begin
        fallback_mode <= mbx_wdata_in[7:0];
      end else if (mbx_index_in == IDX_FALLBACK_PATTERN) begin
        fallback_pattern <= mbx_wdata_in[7:0];
      end
    end
  end

  // restore request: stored now, acted on at restart
  // a write in the restart cycle is kept for the next restart
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      factory_restore_request <= RST_FACTORY_RESTORE;
    end else if (restore_wr) begin
      factory_restore_request <= mbx_wdata_in[7:0];
    end else if (restart_in) begin
      factory_restore_request <= FR_NORMAL;
    end
  end

  // one-cycle restore pulse when a restart finds a request
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      factory_restore_out <= 1'b0;
    end else begin
      factory_restore_out <= restart_in && (factory_restore_request == FR_RESTORE);
    end
  end

  // cyclic exchange: output byte in, input and health out
  // images sampled at the grant, so the master sees one set
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      output_image <= 8'h00;
      cyc_in_byte_out <= 8'h00;
      cyc_health_out <= 32'h0000_0000;
    end else if (grant == SSPI_GR_CYC) begin
      output_image <= cyc_out_byte_in;
      cyc_in_byte_out <= input_image;
      cyc_health_out <= health_word;
    end
  end

  // output selection: live image or fallback
  // hold mode feeds dig_out back, freezing the last outputs
  always_comb begin
    if (is_op) begin
      next_dig = output_image[3:0];
    end else begin
      case (fallback_mode)
        FB_LOW: next_dig = 4'h0;
        FB_HIGH: next_dig = 4'hf;
        FB_HOLD: next_dig = dig_out;
        FB_PATTERN: next_dig = fallback_pattern[3:0];
        default: next_dig = 4'h0;
      endcase
    end
  end

  // physical outputs, registered so hold mode has a last value
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      dig_out <= RST_OUTPUTS;
    end else begin
      dig_out <= next_dig;
    end
  end

  // state code mirror for the master
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      node_state_out <= ST_INIT;
    end else begin
      node_state_out <= node_state_in;
    end
  end
endmodule

// ==== sspi_properties.sv ====
// sspi_properties: port-level checks on sspi_top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
module sspi_chk
  import sspi_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [3:0] node_state_in,
  input wire logic restart_in,
  input wire logic mbx_req_in,
  input wire logic cyc_req_in,
  input wire logic [7:0] cyc_out_byte_in,
  input wire logic mbx_ack_out,
  input wire logic cyc_ack_out,
  input wire logic [31:0] cyc_health_out,
  input wire logic [3:0] node_state_out,
  input wire logic [3:0] dig_out,
  input wire logic factory_restore_out
);
  // every check on the node clock
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // cyclic grant while operational
  sequence s_take;
    cyc_ack_out && node_state_in == ST_OP;
  endsequence
  // quiet non-operational stretch
  sequence s_calm;
    (node_state_in != ST_OP && !mbx_req_in) [*4];
  endsequence
  a_mbx_first: assert property (mbx_req_in |-> mbx_ack_out && !cyc_ack_out)
    else $error("cyclic grant beside mailbox");
  a_cyc_grant: assert property (cyc_req_in && !mbx_req_in |-> cyc_ack_out)
    else $error("cyclic request not granted");
  a_grant_cause: assert property (cyc_ack_out |-> cyc_req_in && !mbx_req_in)
    else $error("cyclic grant without cause");
  a_state_copy: assert property ($past(rst_b_in)
    |-> node_state_out == $past(node_state_in))
    else $error("state code not mirrored");
  a_health_pad: assert property (cyc_health_out[31:6] == 26'h0)
    else $error("health upper bits set");
  a_op_follow: assert property (s_take ##1 (node_state_in == ST_OP) [*2]
    |-> dig_out == $past(cyc_out_byte_in[3:0], 2))
    else $error("outputs not from output byte");
  a_fb_steady: assert property (s_calm |-> $stable(dig_out))
    else $error("fallback outputs moved");
  a_restore_pulse: assert property (factory_restore_out
    |-> $past(restart_in) ##1 !factory_restore_out)
    else $error("restore pulse not after restart");
endmodule
bind sspi_top sspi_chk u_chk (.*);

// ==== sspi_master_model.sv ====
// sspi_master_model: cyclic side of the network master
// assumes the node clock and a combinational grant from the node
`timescale 1ns/1ns
module sspi_master_model (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic run_in,
  input wire logic [7:0] byte_in,
  input wire logic ack_in,
  output logic req_out,
  output logic [7:0] byte_out
);
  // hold request until granted, then release with inverted data
  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      req_out <= 1'b0;
      byte_out <= 8'h00;
    end else if (req_out && ack_in) begin
      req_out <= 1'b0;
      byte_out <= ~byte_out;
    end else if (!req_out && run_in) begin
      req_out <= 1'b1;
      byte_out <= byte_in;
    end
  end
endmodule

// ==== tb_top.sv ====
// tb_top: mailbox and cyclic tests of sspi_top
// assumes the master model drives the cyclic request
`timescale 1ns/1ns
module tb_top
  import sspi_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0, restart_in = 1'b0, mbx_req_in = 1'b0, mbx_write_in = 1'b0;
  logic [3:0] node_state_in = ST_PREOP;
  logic [7:0] dig_in = 8'h81, mbx_sub_in = 8'h00, cyc_out_byte_in;
  logic [5:0] fault_in = 6'h21;
  logic [15:0] mbx_index_in = 16'h0;
  logic [31:0] mbx_wdata_in = 32'h0, mbx_rdata_out, cyc_health_out;
  logic mbx_ack_out, mbx_err_out, cyc_req_in, cyc_ack_out, factory_restore_out;
  logic [7:0] cyc_in_byte_out;
  logic [3:0] node_state_out, dig_out;
  int bad_count = 0, n_tests = 0, cycles = 0;
  logic [3:0] fbx [4] = '{4'h0, 4'hf, 4'ha, 4'h6};
  sspi_top dut (.*);
  sspi_master_model u_mst (.clock_in(clock_in), .rst_b_in(rst_b_in), .run_in(1'b1),
    .byte_in(8'h0a), .ack_in(cyc_ack_out), .req_out(cyc_req_in), .byte_out(cyc_out_byte_in));
  // one mailbox access, result settled on return
  task mb(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    @(posedge clock_in);
    mbx_req_in <= 1'b1;
    mbx_write_in <= w;
    mbx_index_in <= i;
    mbx_sub_in <= s;
    mbx_wdata_in <= d;
    @(posedge clock_in);
    mbx_req_in <= 1'b0;
    @(posedge clock_in);
    #1;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] exp);
    mb(1'b0, i, s, 32'h0);
    chk(mbx_rdata_out, exp);
    chk(32'(mbx_err_out), 32'h0);
  endtask
  task wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic e);
    mb(1'b1, i, s, d);
    chk(32'(mbx_err_out), 32'(e));
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // clock and hang guard
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(IDX_OUTPUT_MAP, SUB_ENTRY, {IDX_OUTPUT_IMAGE, SUB_ENTRY, LEN_BYTE});
    rd(IDX_INPUT_MAP, SUB_ENTRY, {IDX_INPUT_IMAGE, SUB_ENTRY, LEN_BYTE});
    rd(IDX_HEALTH_MAP, SUB_ENTRY, {IDX_HEALTH_WORD, SUB_ENTRY, LEN_WORD});
    rd(IDX_FALLBACK_MODE, SUB_COUNT, 32'h0);
    rd(IDX_INPUT_IMAGE, SUB_ENTRY, 32'h81);
    rd(IDX_HEALTH_WORD, SUB_ENTRY, 32'h21);
    chk(cyc_health_out, 32'h21);
    chk(32'(cyc_in_byte_out), 32'h81);
    wr(IDX_INPUT_IMAGE, SUB_ENTRY, 32'h0, 1'b1);
    wr(IDX_FALLBACK_MODE, SUB_COUNT, 32'h4, 1'b1);
    wr(IDX_FACTORY_RESTORE, SUB_COUNT, 32'h2, 1'b1);
    wr(IDX_FACTORY_RESTORE, SUB_COUNT, 32'h1, 1'b0);
    repeat (4) @(posedge clock_in);
    #1 chk(32'(factory_restore_out), 32'h0);
    @(posedge clock_in);
    restart_in <= 1'b1;
    @(posedge clock_in);
    restart_in <= 1'b0;
    #1 chk(32'(factory_restore_out), 32'h1);
    rd(IDX_FACTORY_RESTORE, SUB_COUNT, 32'h0);
    wr(IDX_FALLBACK_PATTERN, SUB_ENTRY, 32'hf6, 1'b0);
    // every mode: operational, then fallback
    for (int m = 0; m < 4; m++) begin
      wr(IDX_FALLBACK_MODE, SUB_COUNT, 32'(m), 1'b0);
      @(posedge clock_in);
      node_state_in <= ST_OP;
      repeat (8) @(posedge clock_in);
      #1 chk(32'(dig_out), 32'ha);
      chk(32'(node_state_out), 32'(ST_OP));
      @(posedge clock_in);
      node_state_in <= 4'h4;
      repeat (8) @(posedge clock_in);
      #1 chk(32'(dig_out), 32'(fbx[m]));
      @(posedge clock_in);
      node_state_in <= ST_PREOP;
    end
    @(posedge clock_in);
    node_state_in <= ST_OP;
    wr(IDX_FALLBACK_MODE, SUB_COUNT, 32'h0, 1'b1);
    rd(IDX_FALLBACK_MODE, SUB_COUNT, 32'h3);
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    rd(IDX_FALLBACK_MODE, SUB_COUNT, 32'h0);
    complete_run();
  end
endmodule
